// File: hw/core_reset_port_timer_control.sv
// reset sequencing, I/O port registers and timer/counter with shared prescaler
`timescale 1ns/1ps
`default_nettype none
`include "crpt_defs.svh"
// Behaviour
// (RQ1) reset pin, emulation program pin and watchdog each cause the same reset
// (RQ2) any reset sets every port direction bit to one
// (RQ3) timeout and power-down flags record which source caused the reset
// (RQ4) emulation program reset sets both flags and enables code download
// (RQ5) reset clears watchdog, sets option bits to one except watchdog enable
// (RQ6) program counter loads the reset vector, a parameter defaulting to 0x7FF
// (RQ7) reset clears both instruction bank select bits
// (RQ8) reset clears the fetched instruction word so a no-op runs first
// (RQ9) each port write pulses its own strobe for exactly one clock
// (RQ10) reset leaves port data alone; outputs start at power-up state
// (RQ11) written port value appears right after the edge ending the write
// (RQ12) port input sampled at the edge before the read; write-then-read sees old
// (RQ13) timer count increments once per edge from source or prescaler
// (RQ14) time base is clock divided by four or the timer clock pin
// (RQ15) one prescaler, routed ahead of the timer or after the watchdog
// (RQ16) option bits: watchdog enable, clock select, edge select, assignment
// (RQ17) timer-side rate field 0,1,1 divides by sixteen
// (RQ18) power-down instruction clears power-down flag; watchdog reset clears timeout
// (RQ19) clearing the watchdog also clears the prescaler when assigned to it
// (RQ20) option register is write-only and reads as zero
// (RQ21) timer clock pin is synchronised so each edge gives one count enable
// (RQ22) timer count wraps from its maximum to zero
module core_reset_port_timer_control #(
  parameter logic [10:0] RESET_VECTOR = `PC_RESET,
  parameter logic [14:0] WDT_TOP = `WDT_TOP
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic extResetPin,
  input wire logic emuRomProgram_n,
  input wire logic timerClockPin,
  input wire logic [23:0] portIn,
  output wire logic [23:0] portOut,
  output wire logic [23:0] portDir,
  output wire logic [2:0] portStrobe,
  output logic coreReset,
  output logic [10:0] programCounter,
  output logic [11:0] instrWord,
  output logic downloadEnable
);
  localparam logic [26:0] PIN_IDLE = `PIN_IDLE;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    return adr[7:2] == ofs[7:2];
  endfunction : hit

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [26:0] pinRaw;
  logic [26:0] s1_ff;
  logic [26:0] s2_ff;
  logic [26:0] s3_ff;
  logic [26:0] pinQ_ff;
  logic extQ;
  logic emuOn;
  logic tmrQ;
  logic [23:0] portQ;

  assign pinRaw = {timerClockPin, emuRomProgram_n, extResetPin, portIn};

  // a level counts only once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s1_ff <= PIN_IDLE;
      s2_ff <= PIN_IDLE;
      s3_ff <= PIN_IDLE;
      pinQ_ff <= PIN_IDLE;
    end else begin
      s1_ff <= pinRaw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      pinQ_ff <= (s3_ff & ~(s2_ff ^ s3_ff)) | (pinQ_ff & (s2_ff ^ s3_ff));
    end
  end

  assign portQ = pinQ_ff[23:0];
  assign extQ = pinQ_ff[24];
  assign emuOn = ~pinQ_ff[25];
  assign tmrQ = pinQ_ff[26];

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic ack_ff;
  logic [31:0] dat_ff;
  logic req;
  logic wr;
  logic cmdPwrdn;
  logic cmdRwt;

  assign req = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign cmdPwrdn = wr && hit(wb_adr_i, `OFS_COMMAND) && wb_dat_i[`CMD_POWER_DOWN_INSTRUCTION];
  assign cmdRwt = wr && hit(wb_adr_i, `OFS_COMMAND) && wb_dat_i[`CMD_RWT];

  // ----------------------------------------
  // reset sources
  // ----------------------------------------
  logic wdtFire;
  logic anyRst;
  crpt_pkg::resetCause_e nxtCause;
  crpt_pkg::resetCause_e cause_ff;
  logic coreReset_ff;
  logic to_ff;
  logic pd_ff;
  logic download_ff;

  assign anyRst = extQ || emuOn || wdtFire; // see (RQ1)

  always_comb begin
    if (emuOn) begin
      nxtCause = crpt_pkg::CAUSE_EMU;
    end else if (extQ) begin
      nxtCause = crpt_pkg::CAUSE_EXT;
    end else if (wdtFire) begin
      nxtCause = crpt_pkg::CAUSE_WDT;
    end else begin
      nxtCause = crpt_pkg::CAUSE_NONE;
    end
  end

  always_ff @(posedge clk_sys) begin
    coreReset_ff <= sys_rst || anyRst;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      to_ff <= 1'b1;
      pd_ff <= 1'b1;
      cause_ff <= crpt_pkg::CAUSE_POWER;
    end else if (anyRst) begin
      cause_ff <= nxtCause;
      case (nxtCause) // see (RQ3)
        crpt_pkg::CAUSE_EMU: begin
          to_ff <= 1'b1; // see (RQ4)
          pd_ff <= 1'b1;
        end
        crpt_pkg::CAUSE_EXT: begin
          to_ff <= 1'b1;
        end
        crpt_pkg::CAUSE_WDT: begin
          to_ff <= 1'b0; // see (RQ18)
        end
        default: begin
          to_ff <= to_ff;
        end
      endcase
    end else if (cmdPwrdn) begin
      to_ff <= 1'b1;
      pd_ff <= 1'b0; // see (RQ18)
    end else if (cmdRwt) begin
      to_ff <= 1'b1;
      pd_ff <= 1'b1;
    end
  end

  // download stays enabled while the program pin holds the core in reset
  always_ff @(posedge clk_sys) begin
    download_ff <= !sys_rst && emuOn; // see (RQ4)
  end

  // ----------------------------------------
  // status, option, counter and pipeline
  // ----------------------------------------
  logic [1:0] bank_ff;
  logic [7:0] opt_ff;
  logic [10:0] pc_ff;
  logic [11:0] instr_ff;

  always_ff @(posedge clk_sys) begin
    if (sys_rst || anyRst) begin
      bank_ff <= 2'h0; // see (RQ7)
    end else if (wr && hit(wb_adr_i, `OFS_STATUS)) begin
      bank_ff <= wb_dat_i[`ST_IB_HI:`ST_IB_LO];
    end
  end

  // enable bit starts low at power-up, then survives every other reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      opt_ff <= `OPT_ONES_MASK;
    end else if (anyRst) begin
      opt_ff <= opt_ff | `OPT_ONES_MASK; // see (RQ5)
    end else if (wr && hit(wb_adr_i, `OFS_OPTION)) begin
      opt_ff <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || anyRst) begin
      pc_ff <= RESET_VECTOR; // see (RQ6)
      instr_ff <= `INSTR_NOP; // see (RQ8)
    end
  end

  // ----------------------------------------
  // time base, watchdog and prescaler
  // ----------------------------------------
  logic [3:0] divCnt_ff;
  logic [14:0] wdtCnt_ff;
  logic tmrPrev_ff;
  logic [7:0] count_ff;
  logic tick4;
  logic tick16;
  logic wdtEn;
  logic toWatchdog;
  logic wdtOver;
  logic extEdge;
  logic srcTick;
  logic psIn;
  logic psOut;
  logic timerTick;
  logic timerWr;

  assign tick4 = (divCnt_ff & `TMR_DIV_MASK) == `TMR_DIV_MASK;
  assign tick16 = (divCnt_ff & `WDT_DIV_MASK) == `WDT_DIV_MASK;
  assign wdtEn = opt_ff[`OPT_WDT]; // see (RQ16)
  assign toWatchdog = opt_ff[`OPT_PRESCALER_ASSIGNMENT]; // see (RQ16)
  assign wdtOver = tick16 && wdtEn && (wdtCnt_ff == WDT_TOP);
  assign extEdge = opt_ff[`OPT_TSE] ? (tmrQ && !tmrPrev_ff) : (!tmrQ && tmrPrev_ff); // see (RQ21)
  assign srcTick = opt_ff[`OPT_TCS] ? extEdge : tick4; // see (RQ14)
  assign psIn = toWatchdog ? wdtOver : srcTick; // see (RQ15)
  assign wdtFire = toWatchdog ? psOut : wdtOver;
  assign timerTick = toWatchdog ? srcTick : psOut; // see (RQ15)
  assign timerWr = wr && hit(wb_adr_i, `OFS_TIMER);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      divCnt_ff <= 4'h0;
      tmrPrev_ff <= 1'b0;
    end else begin
      divCnt_ff <= divCnt_ff + 4'h1;
      tmrPrev_ff <= tmrQ;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || anyRst || cmdRwt) begin
      wdtCnt_ff <= 15'h0000; // see (RQ5)
    end else if (wdtOver) begin
      wdtCnt_ff <= 15'h0000; // see (RQ15)
    end else if (tick16 && wdtEn) begin
      wdtCnt_ff <= wdtCnt_ff + 15'h0001;
    end
  end

  prescale_unit u_prescale (
    .clk(clk_sys),
    .rst(sys_rst),
    .clear(anyRst || (cmdRwt && toWatchdog)), // see (RQ19)
    .tickIn(psIn),
    .forTimer(!toWatchdog),
    .rate(opt_ff[`OPT_PS_HI:0]),
    .tickOut(psOut)
  );

  // a software load beats a count arriving in the same cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      count_ff <= 8'h00;
    end else if (timerWr) begin
      count_ff <= wb_dat_i[7:0];
    end else if (timerTick) begin
      count_ff <= count_ff + 8'h01; // see (RQ13) (RQ22)
    end
  end

  // ----------------------------------------
  // port registers
  // ----------------------------------------
  for (genvar p = 0; p < 3; p++) begin : g_port
    localparam logic [7:0] DATA_OFS = 8'(`OFS_PORT_DATA + 8'(4 * p));
    localparam logic [7:0] DIR_OFS = 8'(`OFS_PORT_DIR + 8'(4 * p));
    logic [7:0] out_ff = 8'h00;
    logic [7:0] dir_ff;
    logic stb_ff;

    // no reset: data keeps its current value through every reset
    always_ff @(posedge clk_sys) begin
      if (wr && hit(wb_adr_i, DATA_OFS)) begin
        out_ff <= wb_dat_i[7:0]; // see (RQ10) (RQ11)
      end
    end

    always_ff @(posedge clk_sys) begin
      stb_ff <= !sys_rst && wr && hit(wb_adr_i, DATA_OFS); // see (RQ9)
    end

    always_ff @(posedge clk_sys) begin
      if (sys_rst || anyRst) begin
        dir_ff <= `DIR_RESET; // see (RQ2)
      end else if (wr && hit(wb_adr_i, DIR_OFS)) begin
        dir_ff <= wb_dat_i[7:0];
      end
    end

    assign portOut[p*8 +: 8] = out_ff;
    assign portDir[p*8 +: 8] = dir_ff;
    assign portStrobe[p] = stb_ff;
  end

  // ----------------------------------------
  // read path and acknowledge
  // ----------------------------------------
  logic [31:0] rd;

  always_comb begin
    rd = 32'h0000_0000;
    if (hit(wb_adr_i, `OFS_STATUS)) begin
      rd[7:0] = {1'b0, bank_ff, to_ff, pd_ff, 3'h0};
    end else if (hit(wb_adr_i, `OFS_TIMER)) begin
      rd[7:0] = count_ff;
    end else if (hit(wb_adr_i, `OFS_CAUSE)) begin
      rd[2:0] = cause_ff;
    end else if (hit(wb_adr_i, `OFS_PC)) begin
      rd[10:0] = pc_ff;
    end else if (hit(wb_adr_i, `OFS_INSTR)) begin
      rd[11:0] = instr_ff;
    end
    for (int p = 0; p < 3; p++) begin
      if (hit(wb_adr_i, 8'(`OFS_PORT_DATA + 8'(4 * p)))) begin
        rd[7:0] = portQ[p*8 +: 8]; // see (RQ12)
      end
      if (hit(wb_adr_i, 8'(`OFS_PORT_DIR + 8'(4 * p)))) begin
        rd[7:0] = portDir[p*8 +: 8];
      end
    end
  end

  // option register has no read path at all
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= req;
      if (req && !wb_we_i) begin
        dat_ff <= rd; // see (RQ20)
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign coreReset = coreReset_ff;
  assign programCounter = pc_ff;
  assign instrWord = instr_ff;
  assign downloadEnable = download_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence sPortWr;
    req && wb_we_i && wb_sel_i[0] && hit(wb_adr_i, `OFS_PORT_DATA);
  endsequence

  a_dir_all_ones: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (RQ2)
    anyRst |=> portDir == {3{`DIR_RESET}}) else $error("direction not all ones after reset");
  a_watchdog_flag: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (RQ3)
    nxtCause == crpt_pkg::CAUSE_WDT |=> !to_ff && pd_ff == $past(pd_ff)) else $error("watchdog flags wrong");
  a_emu_preset: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (RQ4)
    emuOn |=> to_ff && pd_ff && downloadEnable) else $error("emulation reset flags wrong");
  a_option_ones: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (RQ5)
    anyRst |=> (opt_ff & `OPT_ONES_MASK) == `OPT_ONES_MASK && opt_ff[`OPT_WDT] == $past(opt_ff[`OPT_WDT])
    && wdtCnt_ff == 15'h0000) else $error("option or watchdog not reset");
  a_pc_vector: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (RQ6)
    anyRst |=> programCounter == RESET_VECTOR) else $error("pc not at reset vector");
  a_bank_cleared: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (RQ7)
    anyRst |=> bank_ff == 2'h0) else $error("bank bits not cleared");
  a_pipe_flush: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (RQ8)
    anyRst |=> instrWord == `INSTR_NOP) else $error("pipeline not flushed");
  a_port_strobe: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (RQ9)
    sPortWr |=> (portStrobe[0] && portOut[7:0] == $past(wb_dat_i[7:0])) ##1 !portStrobe[0])
    else $error("port strobe or data wrong");
  a_port_sample: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (RQ12)
    (req && !wb_we_i && hit(wb_adr_i, `OFS_PORT_DATA)) |=> wb_dat_o[7:0] == $past(portQ[7:0]))
    else $error("port read not sampled value");
  a_timer_step: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (RQ22)
    (timerTick && !timerWr) |=> count_ff == $past(count_ff) + 8'h01) else $error("timer step wrong");
  a_power_down_instruction_clear: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (RQ18)
    (cmdPwrdn && !anyRst) |=> !pd_ff && to_ff) else $error("power-down flag not cleared");
  a_edge_single: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (RQ21)
    extEdge |=> !extEdge) else $error("pin edge longer than one cycle");
endmodule : core_reset_port_timer_control
`default_nettype wire

// File: pkg/crpt_defs.svh
// register offsets, field positions, reset values and counts for the reset/port/timer block
`ifndef CRPT_DEFS_SVH
`define CRPT_DEFS_SVH
`define OFS_STATUS 8'h00
`define OFS_OPTION 8'h04
`define OFS_TIMER 8'h08
`define OFS_COMMAND 8'h0C
`define OFS_PORT_DATA 8'h10
`define OFS_PORT_DIR 8'h1C
`define OFS_CAUSE 8'h28
`define OFS_PC 8'h2C
`define OFS_INSTR 8'h30
`define ST_IB_HI 6
`define ST_IB_LO 5
`define ST_TO 4
`define ST_PD 3
`define OPT_WDT 6
`define OPT_TCS 5
`define OPT_TSE 4
`define OPT_PRESCALER_ASSIGNMENT 3
`define OPT_PS_HI 2
`define CMD_POWER_DOWN_INSTRUCTION 0
`define CMD_RWT 1
`define DIR_RESET 8'hFF
`define OPT_ONES_MASK 8'hBF
`define PC_RESET 11'h7FF
`define INSTR_NOP 12'h000
`define WDT_TOP 15'h3FFF
`define TMR_DIV_MASK 4'h3
`define WDT_DIV_MASK 4'hF
`define PIN_IDLE 27'h200_0000
`endif

// File: pkg/crpt_pkg.sv
// types shared by the reset, port and timer logic
package crpt_pkg;
  typedef enum logic [2:0] {
    CAUSE_NONE = 3'h0,
    CAUSE_POWER = 3'h1,
    CAUSE_EMU = 3'h2,
    CAUSE_EXT = 3'h3,
    CAUSE_WDT = 3'h4
  } resetCause_e;
endpackage : crpt_pkg

// File: hw/prescale_unit.sv
// shared 8-bit prescale counter for timer or watchdog
`timescale 1ns/1ps
`default_nettype none
module prescale_unit (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic tickIn,
  input wire logic forTimer,
  input wire logic [2:0] rate,
  output logic tickOut
);
  logic [7:0] count_ff;
  logic [3:0] stages;
  logic [7:0] mask;

  // timer side divides by 2^(rate+1), watchdog side by 2^rate
  always_comb begin
    stages = {1'b0, rate} + {3'h0, forTimer};
    mask = 8'((9'h001 << stages) - 9'h001);
    tickOut = tickIn && ((count_ff & mask) == mask);
  end

  always_ff @(posedge clk) begin
    if (rst || clear) begin
      count_ff <= 8'h00;
    end else if (tickIn) begin
      count_ff <= count_ff + 8'h01;
    end
  end

  a_rate_sixteen: assert property (@(posedge clk) disable iff (rst) // see (RQ17)
    (tickOut && forTimer && rate == 3'h3) |-> count_ff[3:0] == 4'hF)
    else $error("prescaler output off the divide-by-16 boundary");
endmodule : prescale_unit
`default_nettype wire

// File: dv/io_far_side.sv
// far-side model: port pad buffers, strobe-fed fifo capture, timer clock pin
`timescale 1ns/1ps
`default_nettype none
module io_far_side (
  input wire logic clk_sys,
  input wire logic [23:0] portOut,
  input wire logic [23:0] portDir,
  input wire logic [2:0] portStrobe,
  input wire logic [23:0] padDrive,
  output logic [23:0] portIn,
  output logic timerClockPin
);
  // ---------------------------------------------------------------
  // pads and capture
  // ---------------------------------------------------------------
  int strobeCycles [3] = '{0, 0, 0};
  logic [23:0] fifoLast = 24'h00_0000;
  // output bits loop back through the pad, input bits come from outside
  assign portIn = (portOut & ~portDir) | (padDrive & portDir);
  // counts strobe-high cycles, so a stretched strobe shows as extra counts
  always @(posedge clk_sys) begin
    for (int i = 0; i < 3; i++) begin
      if (portStrobe[i]) begin
        strobeCycles[i] <= strobeCycles[i] + 1;
        fifoLast[i*8 +: 8] <= portOut[i*8 +: 8];
      end
    end
  end
  // ---------------------------------------------------------------
  // timer pin, low between bursts
  // ---------------------------------------------------------------
  initial timerClockPin = 1'b0;
  task automatic pulses(input int n);
    repeat (n) begin
      repeat (8) @(posedge clk_sys);
      timerClockPin <= 1'b1;
      repeat (8) @(posedge clk_sys);
      timerClockPin <= 1'b0;
    end
    repeat (8) @(posedge clk_sys);
  endtask : pulses
endmodule : io_far_side
`default_nettype wire

// File: dv/testbench.sv
// bus-driven testbench for the reset, port and timer block
`timescale 1ns/1ps
`default_nettype none
`include "crpt_defs.svh"
module testbench;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam logic [10:0] PC_VEC = 11'h1FF;
  logic clk_sys, sys_rst, wbCyc, wbStb, wbWe, wbAck, extResetPin, emuRomProgram_n;
  logic [7:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatI, wbDatO;
  logic [23:0] portIn, portOut, portDir, padDrive;
  logic [2:0] portStrobe;
  logic timerClockPin, coreReset, downloadEnable;
  logic [10:0] programCounter;
  logic [11:0] instrWord;
  int nFail = 0;
  int totalChecks = 0;
  core_reset_port_timer_control #(.RESET_VECTOR(PC_VEC), .WDT_TOP(15'h0003)) uut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
    .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .extResetPin(extResetPin),
    .emuRomProgram_n(emuRomProgram_n), .timerClockPin(timerClockPin), .portIn(portIn),
    .portOut(portOut), .portDir(portDir), .portStrobe(portStrobe), .coreReset(coreReset),
    .programCounter(programCounter), .instrWord(instrWord), .downloadEnable(downloadEnable));
  io_far_side far (.clk_sys(clk_sys), .portOut(portOut), .portDir(portDir),
    .portStrobe(portStrobe), .padDrive(padDrive), .portIn(portIn), .timerClockPin(timerClockPin));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic finalReport();
    if (nFail == 0 && totalChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finalReport
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    totalChecks++;
    if (got !== exp) begin
      nFail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  // timer phase is free-running, so counts are judged within a window
  task automatic chkRange(input logic [31:0] got, input int lo, input int hi, input string what);
    totalChecks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      nFail++;
      $display("mismatch at %0t: %s got %h outside %0d..%0d", $time, what, got, lo, hi);
    end
  endtask : chkRange
  task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] wd, output logic [31:0] rd);
    int k;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbSel <= 4'h1;
    wbAdr <= adr;
    wbDatI <= {24'h00_0000, wd};
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (wbAck !== 1'b1 && k < 20);
    rd = wbDatO;
    if (wbAck !== 1'b1) begin
      nFail++;
      $display("mismatch at %0t: no bus answer", $time);
      finalReport();
    end
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    wbSel <= 4'h0;
    @(posedge clk_sys);
  endtask : bus
  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    logic [31:0] rd;
    bus(1'b1, adr, d, rd);
  endtask : wr
  task automatic rdChk(input logic [7:0] adr, input logic [7:0] exp, input string what);
    logic [31:0] rd;
    bus(1'b0, adr, 8'h00, rd);
    chk(rd, {24'h00_0000, exp}, what);
  endtask : rdChk
  task automatic rdRange(input logic [7:0] adr, input int lo, input int hi, input string what);
    logic [31:0] rd;
    bus(1'b0, adr, 8'h00, rd);
    chkRange(rd, lo, hi, what);
  endtask : rdRange
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : idle
  task automatic resetView(input logic [7:0] cause, input logic [7:0] status);
    chk({8'h00, portDir}, 32'hFF_FFFF, "dir");
    chk({21'h0, programCounter}, {21'h0, PC_VEC}, "pc");
    chk({20'h0, instrWord}, 32'h0, "instr");
    rdChk(`OFS_CAUSE, cause, "cause");
    rdChk(`OFS_STATUS, status, "status");
  endtask : resetView
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    sys_rst <= 1'b1;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    wbSel <= 4'h0;
    wbAdr <= 8'h00;
    wbDatI <= 32'h0;
    extResetPin <= 1'b0;
    emuRomProgram_n <= 1'b1;
    padDrive <= 24'hA5_A5A5;
    idle(10);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    resetView(8'h01, 8'h18);
    rdChk(8'h3C, 8'h00, "unmapped");
    // ports: old value on read right after write
    wr(`OFS_PORT_DIR, 8'h00);
    wr(`OFS_PORT_DATA, 8'h57);
    idle(6);
    wr(`OFS_PORT_DATA, 8'h38);
    rdChk(`OFS_PORT_DATA, 8'h57, "port early read");
    idle(4);
    rdChk(`OFS_PORT_DATA, 8'h38, "port late read");
    rdChk(`OFS_PORT_DATA + 8'h04, 8'hA5, "input port");
    wr(`OFS_PORT_DATA + 8'h08, 8'hC3);
    chk(far.strobeCycles[0], 2, "strobe0");
    chk(far.strobeCycles[1], 0, "strobe1");
    chk(far.strobeCycles[2], 1, "strobe2");
    chk({8'h00, far.fifoLast[23:16]}, 32'hC3, "fifo capture");
    // internal base, prescaler to timer, rate 3: one count per 64 clocks
    wr(`OFS_OPTION, 8'h13);
    rdChk(`OFS_OPTION, 8'h00, "option reads zero");
    wr(`OFS_TIMER, 8'h00);
    idle(640);
    rdRange(`OFS_TIMER, 9, 11, "timer rate");
    // pin source, rising edge, prescaler to watchdog, wrap past max
    wr(`OFS_OPTION, 8'h38);
    wr(`OFS_TIMER, 8'hFE);
    far.pulses(3);
    rdChk(`OFS_TIMER, 8'h01, "pin count wrap");
    wr(`OFS_OPTION, 8'h28);
    wr(`OFS_TIMER, 8'h00);
    far.pulses(2);
    rdChk(`OFS_TIMER, 8'h02, "falling pin count");
    // bank bits and power-down, then the reset pin
    wr(`OFS_STATUS, 8'h60);
    wr(`OFS_COMMAND, 8'h01);
    rdChk(`OFS_STATUS, 8'h70, "after power-down");
    extResetPin <= 1'b1;
    idle(6);
    chk({31'h0, coreReset}, 32'h1, "core reset");
    extResetPin <= 1'b0;
    idle(8);
    resetView(8'h03, 8'h10);
    chk({24'h0, portOut[7:0]}, 32'h38, "port kept");
    // emulation program reset
    emuRomProgram_n <= 1'b0;
    idle(6);
    chk({31'h0, downloadEnable}, 32'h1, "download");
    emuRomProgram_n <= 1'b1;
    idle(8);
    resetView(8'h02, 8'h18);
    // watchdog: fed, then starved, then disabled
    wr(`OFS_OPTION, 8'h40);
    repeat (5) begin
      idle(20);
      wr(`OFS_COMMAND, 8'h02);
    end
    rdChk(`OFS_CAUSE, 8'h02, "fed watchdog");
    idle(100);
    resetView(8'h04, 8'h08);
    wr(`OFS_COMMAND, 8'h02);
    wr(`OFS_OPTION, 8'h00);
    wr(`OFS_COMMAND, 8'h02);
    idle(200);
    rdChk(`OFS_STATUS, 8'h18, "watchdog off");
    // prescaler after the watchdog, rate 1: two overflows per reset
    wr(`OFS_OPTION, 8'h49);
    wr(`OFS_COMMAND, 8'h02);
    idle(70);
    wr(`OFS_COMMAND, 8'h02);
    idle(70);
    rdChk(`OFS_STATUS, 8'h18, "prescaled watchdog fed");
    idle(60);
    rdChk(`OFS_STATUS, 8'h08, "prescaled watchdog fired");
    finalReport();
  end
endmodule : testbench
`default_nettype wire
